// >>> design/vchop_pkg.sv
// Overview of operation
// - Voltage mode below lower velocity threshold
// - Keep last amplitude while current chopping
// - Auto scaling select picks fixed or regulated
// - Chop rate select picks one of four spans, two periods each
// - Zero gain disables voltage mode entirely
// - Fixed amplitude: fixed value, re-entry limit
// - Standstill option: normal, standstill_option, brake LS/HS
// - Standstill option waits for zero delays
// - Zero target current freezes the regulation
// - Regulated scale readable, frozen outside voltage
// - Zero slow decay time switches driver off
// - Blank time 16, 24, 36, 54 cycles
// - Run/hold current is regulation target only when auto
// - Open-load flags show nominal current not reached
// - Interrupted coil holds its open-load flag
// - Gain is proportional coefficient of regulator
// - Auto scaling starts regulating only at standstill
package vchop_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CURRENT = 8'h04;
    localparam logic [7:0] OFS_COOL_THRS = 8'h08;
    localparam logic [7:0] OFS_HIGH_THRS = 8'h0C;
    localparam logic [7:0] OFS_ZERO_WAIT = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_AUTO = 0;
    localparam int CTRL_RATE = 2;
    localparam int CTRL_GAIN = 4;
    localparam int CTRL_AMPL = 8;
    localparam int CTRL_STILL = 16;
    localparam int CTRL_SLOW_DECAY_TIME = 18;
    localparam int CTRL_TBL = 22;
    localparam int CUR_HOLD = 0;
    localparam int CUR_RUN = 8;
    localparam int CUR_HDLY = 16;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CURRENT_RST = 32'h0000_1F00;
    localparam logic [31:0] THRS_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_WAIT_RST = 32'h0000_0000;
    localparam int HDLY_SHIFT = 4;
    localparam int FULLSTEP_MISS_LIMIT = 4;
    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [10:0] SPAN_SEL0 = 11'd1024;
    localparam logic [10:0] SPAN_SEL1 = 11'd683;
    localparam logic [10:0] SPAN_SEL2 = 11'd512;
    localparam logic [10:0] SPAN_SEL3 = 11'd410;
    localparam logic [5:0] BLANK_SEL0 = 6'd16;
    localparam logic [5:0] BLANK_SEL1 = 6'd24;
    localparam logic [5:0] BLANK_SEL2 = 6'd36;
    localparam logic [5:0] BLANK_SEL3 = 6'd54;
    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CM_OFF = 2'b00,
        CM_VOLT = 2'b01,
        CM_CURR = 2'b11,
        CM_STILL = 2'b10
    } chop_mode_t;
    typedef enum logic [2:0] {
        BR_OFF = 3'h0,
        BR_VOLT_PWM = 3'h1,
        BR_CURR_CHOP = 3'h2,
        BR_STANDSTILL_OPTION = 3'h3,
        BR_SHORT_LS = 3'h4,
        BR_SHORT_HS = 3'h5
    } bridge_t;
endpackage

// >>> design/chop_period_divider.sv
`timescale 1ns/1ps
module chop_period_divider
    import vchop_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] rate_sel,
    output logic tick
);
    logic [10:0] cnt_r;
    logic [10:0] span;
    logic [10:0] half;

    // ------------------------------------------------------------
    // Two chopper periods per span, odd spans split unevenly
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (rate_sel)
            2'd0: span = SPAN_SEL0;
            2'd1: span = SPAN_SEL1;
            2'd2: span = SPAN_SEL2;
            2'd3: span = SPAN_SEL3;
        endcase
        half = span >> 1;
    end

    // Wraps early if a smaller span is chosen mid-count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 11'h000;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (cnt_r == half - 11'd1) || (cnt_r >= span - 11'd1);
            cnt_r <= (cnt_r >= span - 11'd1) ? 11'h000 : cnt_r + 11'd1;
        end
    end
endmodule // chop_period_divider

// >>> design/amplitude_regulator.sv
`timescale 1ns/1ps
module amplitude_regulator
    import vchop_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic run_en,
    input wire logic load_fixed,
    input wire logic clamp_en,
    input wire logic [7:0] fixed_amp,
    input wire logic [3:0] gain,
    input wire logic [7:0] target,
    input wire logic [7:0] measured,
    output logic [7:0] scale
);
    // ------------------------------------------------------------
    // Proportional step, saturated to the 8-bit scale
    // ------------------------------------------------------------
    function automatic logic [7:0] p_step(input logic [7:0] cur, input logic [7:0] tgt,
                                          input logic [7:0] meas, input logic [3:0] g);
        logic signed [9:0] err;
        logic signed [14:0] prod;
        logic signed [14:0] sum;
        err = $signed({2'b00, tgt}) - $signed({2'b00, meas});
        prod = (15'(err) * $signed({11'h000, g})) >>> 3;
        sum = $signed({7'h00, cur}) + prod;
        if (sum < 0)
            p_step = 8'h00;
        else if (sum > 15'sd255)
            p_step = 8'hFF;
        else
            p_step = sum[7:0];
    endfunction

    // Holds its value whenever nothing asks it to move
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            scale <= 8'h00;
        else if (load_fixed)
            scale <= fixed_amp;
        else if (clamp_en && scale > fixed_amp)
            scale <= fixed_amp;
        else if (run_en && tick)
            scale <= p_step(scale, target, measured, gain);
    end
endmodule // amplitude_regulator

// >>> design/voltage_chopper_mode_control.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module voltage_chopper_mode_control
    import vchop_pkg::*;
#(
    parameter int VEL_W = 23
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [VEL_W-1:0] ramp_velocity,
    input wire logic velocity_update,
    input wire logic standstill,
    input wire logic fullstep,
    input wire logic [7:0] measured_current,
    input wire logic coil_a_reached,
    input wire logic coil_b_reached,
    input wire logic coil_a_interrupted,
    input wire logic coil_b_interrupted,
    output vchop_pkg::bridge_t bridge_state_r,
    output logic voltage_mode_r,
    output logic [7:0] pwm_amplitude_r,
    output logic blank_r,
    output logic period_tick_r,
    output logic open_load_coil_a,
    output logic open_load_coil_b
);
    import vchop_pkg::*;

    if (VEL_W < 1 || VEL_W > 32)
    begin : g_vel_w_check
        $error("VEL_W must be 1 to 32");
    end

    // ------------------------------------------------------------
    // Register file over APB, zero wait states
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] current_r;
    logic [VEL_W-1:0] cool_threshold_velocity;
    logic [VEL_W-1:0] high_velocity_threshold;
    logic [15:0] zero_wait_delay;
    logic [7:0] scale;
    chop_mode_t state_r;
    chop_mode_t state_nxt;
    logic mapped;
    logic wr_en;

    wire logic autoscale = ctrl_r[CTRL_AUTO];
    wire logic [1:0] chop_rate_select = ctrl_r[CTRL_RATE +: 2];
    wire logic [3:0] regulator_gain = ctrl_r[CTRL_GAIN +: 4];
    wire logic [7:0] fixed_amplitude = ctrl_r[CTRL_AMPL +: 8];
    wire logic [1:0] standstill_option = ctrl_r[CTRL_STILL +: 2];
    wire logic [3:0] slow_decay_time = ctrl_r[CTRL_SLOW_DECAY_TIME +: 4];
    wire logic [1:0] blank_time_select = ctrl_r[CTRL_TBL +: 2];
    wire logic [4:0] hold_current = current_r[CUR_HOLD +: 5];
    wire logic [4:0] run_current = current_r[CUR_RUN +: 5];
    wire logic [3:0] hold_ramp_delay = current_r[CUR_HDLY +: 4];

    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CURRENT) ||
                    (paddr == OFS_COOL_THRS) || (paddr == OFS_HIGH_THRS) ||
                    (paddr == OFS_ZERO_WAIT) || (paddr == OFS_STATUS);
    assign wr_en = psel && penable && pready && pwrite && mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite)
            begin
                unique case (paddr)
                    OFS_CTRL: prdata <= ctrl_r;
                    OFS_CURRENT: prdata <= current_r;
                    OFS_COOL_THRS: prdata <= 32'(cool_threshold_velocity);
                    OFS_HIGH_THRS: prdata <= 32'(high_velocity_threshold);
                    OFS_ZERO_WAIT: prdata <= {16'h0000, zero_wait_delay};
                    OFS_STATUS: prdata <= {18'h00000, bridge_state_r, open_load_coil_b,
                                           open_load_coil_a, voltage_mode_r, scale};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Reserved bits are not stored and read as zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= CTRL_RST;
            current_r <= CURRENT_RST;
            cool_threshold_velocity <= VEL_W'(THRS_RST);
            high_velocity_threshold <= VEL_W'(THRS_RST);
            zero_wait_delay <= ZERO_WAIT_RST[15:0];
        end
        else if (wr_en)
        begin
            unique case (paddr)
                OFS_CTRL: ctrl_r <= {8'h00, pwdata[23:2], 1'h0, pwdata[0]};
                OFS_CURRENT: current_r <= {12'h000, pwdata[19:16], 3'h0, pwdata[12:8],
                                           3'h0, pwdata[4:0]};
                OFS_COOL_THRS: cool_threshold_velocity <= pwdata[VEL_W-1:0];
                OFS_HIGH_THRS: high_velocity_threshold <= pwdata[VEL_W-1:0];
                OFS_ZERO_WAIT: zero_wait_delay <= pwdata[15:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Period divider and blank window
    // ------------------------------------------------------------
    logic tick;
    logic [5:0] blank_cnt_r;
    logic [5:0] blank_len;

    chop_period_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .rate_sel(chop_rate_select),
        .tick(tick)
    );

    always_comb
    begin
        unique case (blank_time_select)
            2'd0: blank_len = BLANK_SEL0;
            2'd1: blank_len = BLANK_SEL1;
            2'd2: blank_len = BLANK_SEL2;
            2'd3: blank_len = BLANK_SEL3;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blank_cnt_r <= 6'h00;
            blank_r <= 1'b0;
            period_tick_r <= 1'b0;
        end
        else
        begin
            period_tick_r <= tick;
            if (tick)
            begin
                blank_cnt_r <= blank_len - 6'd1;
                blank_r <= 1'b1;
            end
            else
            begin
                blank_cnt_r <= (blank_cnt_r != 6'h00) ? blank_cnt_r - 6'd1 : 6'h00;
                blank_r <= blank_cnt_r != 6'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Velocity decision and standstill delay
    // ------------------------------------------------------------
    logic want_volt_r;
    logic [20:0] still_cnt_r;
    logic still_done_r;
    logic started_r;
    wire logic [VEL_W-1:0] vlimit = (cool_threshold_velocity < high_velocity_threshold) ?
                                    cool_threshold_velocity : high_velocity_threshold;
    wire logic [20:0] still_limit = {5'h00, zero_wait_delay} +
                                    21'({hold_ramp_delay, HDLY_SHIFT'(0)});

    // Sampled only on an update; switching waits for a period edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            want_volt_r <= 1'b0;
        else if (velocity_update)
            want_volt_r <= ramp_velocity < vlimit;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            still_cnt_r <= 21'h000000;
            still_done_r <= 1'b0;
        end
        else if (!standstill)
        begin
            still_cnt_r <= 21'h000000;
            still_done_r <= 1'b0;
        end
        else if (tick && !still_done_r)
        begin
            still_cnt_r <= still_cnt_r + 21'd1;
            still_done_r <= still_cnt_r + 21'd1 >= still_limit;
        end
    end

    // ------------------------------------------------------------
    // Chopper mode state machine
    // ------------------------------------------------------------
    wire logic drv_dis = (regulator_gain == 4'h0) || (slow_decay_time == 4'h0);
    wire logic still_ok = still_done_r && hold_current == 5'h00 && standstill_option != 2'd0;

    always_comb
    begin
        state_nxt = state_r;
        if (regulator_gain == 4'h0)
            state_nxt = CM_OFF;
        else if (tick)
        begin
            unique case (state_r)
                CM_OFF: state_nxt = want_volt_r ? CM_VOLT : CM_CURR;
                CM_VOLT: state_nxt = !want_volt_r ? CM_CURR : (still_ok ? CM_STILL : CM_VOLT);
                CM_CURR: state_nxt = want_volt_r ? CM_VOLT : CM_CURR;
                CM_STILL: state_nxt = still_ok ? CM_STILL : CM_VOLT;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= CM_OFF;
        else
            state_r <= state_nxt;
    end

    // Regulation starts at standstill, then runs in motion too
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            started_r <= 1'b0;
        else if (regulator_gain == 4'h0 || !autoscale)
            started_r <= 1'b0;
        else if (state_r == CM_VOLT && standstill)
            started_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // Amplitude regulation
    // ------------------------------------------------------------
    wire logic [4:0] target_cur = still_done_r ? hold_current : run_current;
    wire logic [7:0] target8 = {target_cur, 3'h0};
    wire logic reentry = state_r == CM_CURR && state_nxt == CM_VOLT;
    wire logic reg_run = state_r == CM_VOLT && autoscale && started_r && target_cur != 5'h00;

    amplitude_regulator u_reg (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .run_en(reg_run),
        .load_fixed(state_r == CM_VOLT && !autoscale),
        .clamp_en(reentry && autoscale),
        .fixed_amp(fixed_amplitude),
        .gain(regulator_gain),
        .target(target8),
        .measured(measured_current),
        .scale(scale)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bridge_state_r <= BR_OFF;
            voltage_mode_r <= 1'b0;
            pwm_amplitude_r <= 8'h00;
        end
        else
        begin
            voltage_mode_r <= state_r == CM_VOLT || state_r == CM_STILL;
            pwm_amplitude_r <= (state_r == CM_VOLT) ? scale : 8'h00;
            if (slow_decay_time == 4'h0)
                bridge_state_r <= BR_OFF;
            else
            begin
                unique case (state_r)
                    CM_OFF: bridge_state_r <= BR_CURR_CHOP;
                    CM_VOLT: bridge_state_r <= BR_VOLT_PWM;
                    CM_CURR: bridge_state_r <= BR_CURR_CHOP;
                    CM_STILL: bridge_state_r <= (standstill_option == 2'd1) ? BR_STANDSTILL_OPTION :
                                                (standstill_option == 2'd2) ? BR_SHORT_LS :
                                                BR_SHORT_HS;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Open-load flags
    // ------------------------------------------------------------
    logic [2:0] miss_cnt_r;
    wire logic both_reached = coil_a_reached && coil_b_reached;
    wire logic miss_all = miss_cnt_r >= 3'(FULLSTEP_MISS_LIMIT);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            miss_cnt_r <= 3'h0;
        else if (!voltage_mode_r || both_reached)
            miss_cnt_r <= 3'h0;
        else if (fullstep && !miss_all)
            miss_cnt_r <= miss_cnt_r + 3'd1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            open_load_coil_a <= 1'b0;
            open_load_coil_b <= 1'b0;
        end
        else
        begin
            open_load_coil_a <= coil_a_interrupted ||
                                (voltage_mode_r && (!coil_a_reached || miss_all));
            open_load_coil_b <= coil_b_interrupted ||
                                (voltage_mode_r && (!coil_b_reached || miss_all));
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_fixed_scale;
        (state_r == CM_VOLT && !autoscale && $stable(fixed_amplitude)) [*3]
            |-> pwm_amplitude_r == fixed_amplitude;
    endproperty
    a_fixed_scale: assert property (p_fixed_scale) else $error("fixed amplitude not used");

    property p_slow_decay_time_off;
        slow_decay_time == 4'h0 |=> bridge_state_r == BR_OFF;
    endproperty
    a_slow_decay_time_off: assert property (p_slow_decay_time_off) else $error("driver not off");

    property p_gain_off;
        regulator_gain == 4'h0 |=> !(state_r inside {CM_VOLT, CM_STILL}) ##1 !voltage_mode_r;
    endproperty
    a_gain_off: assert property (p_gain_off) else $error("voltage mode with zero gain");

    property p_switch_on_tick;
        $changed(state_r) && $past(regulator_gain) != 4'h0 |-> $past(tick);
    endproperty
    a_switch_on_tick: assert property (p_switch_on_tick) else $error("switch off edge");

    property p_thresh;
        tick && !drv_dis && want_volt_r && state_r == CM_CURR |=> state_r == CM_VOLT;
    endproperty
    a_thresh: assert property (p_thresh) else $error("voltage mode not entered");

    property p_frozen;
        state_r == CM_CURR && $past(state_r) == CM_CURR |-> $stable(scale);
    endproperty
    a_frozen: assert property (p_frozen) else $error("scale moved in current mode");

    property p_zero_freeze;
        target_cur == 5'h00 && state_r == CM_VOLT && autoscale |=> $stable(scale);
    endproperty
    a_zero_freeze: assert property (p_zero_freeze) else $error("regulation not frozen");

    property p_open_coil;
        coil_a_interrupted ##1 coil_a_interrupted |-> open_load_coil_a;
    endproperty
    a_open_coil: assert property (p_open_coil) else $error("open flag a dropped");

    property p_miss_both;
        miss_all && voltage_mode_r |=> open_load_coil_a && open_load_coil_b;
    endproperty
    a_miss_both: assert property (p_miss_both) else $error("both flags not set");

    property p_blank_len;
        $rose(blank_r) |-> blank_r [*8] ##[9:47] !blank_r;
    endproperty
    a_blank_len: assert property (p_blank_len) else $error("blank window length");

    property p_still_delay;
        $changed(state_r) && state_r == CM_STILL |-> $past(still_done_r) &&
            $past(hold_current) == 5'h00;
    endproperty
    a_still_delay: assert property (p_still_delay) else $error("standstill too early");

    c_volt_to_curr: cover property (state_r == CM_VOLT ##1 state_r == CM_CURR);
    c_reentry: cover property (state_r == CM_CURR ##1 state_r == CM_VOLT);
    c_brake: cover property (bridge_state_r == BR_SHORT_LS);
    c_both_open: cover property (open_load_coil_a && open_load_coil_b);
endmodule // voltage_chopper_mode_control

// >>> verif/coil_bridge_model.sv
`timescale 1ns/1ps
module coil_bridge_model
    import vchop_pkg::*;
(
    input wire logic pclk,
    input wire vchop_pkg::bridge_t bridge,
    input wire logic [7:0] amplitude,
    input wire logic break_a,
    input wire logic break_b,
    output logic [7:0] measured_current,
    output logic fullstep,
    output logic coil_a_reached,
    output logic coil_b_reached,
    output logic coil_a_interrupted,
    output logic coil_b_interrupted
);
    logic [5:0] step_r = 6'h00;
    // Undriven coils give a moving pattern, never a stale value
    always_ff @(posedge pclk)
    begin
        step_r <= step_r + 6'h01;
        measured_current <= (bridge == BR_VOLT_PWM) ? amplitude : {2'h0, step_r};
    end
    assign fullstep = (step_r == 6'h3F);
    assign coil_a_reached = (bridge == BR_VOLT_PWM) && !break_a;
    assign coil_b_reached = (bridge == BR_VOLT_PWM) && !break_b;
    assign coil_a_interrupted = break_a;
    assign coil_b_interrupted = break_b;
endmodule // coil_bridge_model

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
    import vchop_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] q; logic e;} row_t;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic velocity_update = 1'h0, standstill = 1'h0, break_a = 1'h0, break_b = 1'h0, er;
    logic [7:0] paddr = 8'h00, measured_current, pwm_amplitude_r;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [22:0] ramp_velocity = 23'h0;
    logic pready, pslverr, fullstep, coil_a_reached, coil_b_reached, coil_a_interrupted;
    logic coil_b_interrupted, voltage_mode_r, blank_r, period_tick_r;
    logic open_load_coil_a, open_load_coil_b;
    bridge_t bridge_state_r;
    int n_mismatch = 0, samples_checked = 0, c, t;
    // Reserved bits must read back as zero after an all-ones write
    row_t rows [5] = '{'{OFS_CTRL, 32'h00FF_FFFD, 1'h0}, '{OFS_CURRENT, 32'h000F_1F1F, 1'h0},
        '{OFS_COOL_THRS, 32'h007F_FFFF, 1'h0}, '{OFS_ZERO_WAIT, 32'h0000_FFFF, 1'h0},
        '{8'h18, 32'h0, 1'h1}};
    logic [10:0] span [4] = '{SPAN_SEL0, SPAN_SEL1, SPAN_SEL2, SPAN_SEL3};
    logic [5:0] blank [4] = '{BLANK_SEL0, BLANK_SEL1, BLANK_SEL2, BLANK_SEL3};
    bridge_t opt [4] = '{BR_VOLT_PWM, BR_STANDSTILL_OPTION, BR_SHORT_LS, BR_SHORT_HS};

    voltage_chopper_mode_control i_voltage_chopper_mode_control (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ramp_velocity,
        .velocity_update, .standstill, .fullstep, .measured_current, .coil_a_reached,
        .coil_b_reached, .coil_a_interrupted, .coil_b_interrupted, .bridge_state_r,
        .voltage_mode_r, .pwm_amplitude_r, .blank_r, .period_tick_r, .open_load_coil_a,
        .open_load_coil_b);
    coil_bridge_model i_coil_bridge_model (.pclk, .bridge(bridge_state_r),
        .amplitude(pwm_amplitude_r), .break_a, .break_b, .measured_current, .fullstep,
        .coil_a_reached, .coil_b_reached, .coil_a_interrupted, .coil_b_interrupted);

    always #2.5 pclk = ~pclk;

    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic vel(logic [22:0] v, int n);
        ramp_velocity <= v;
        velocity_update <= 1'h1;
        @(posedge pclk);
        velocity_update <= 1'h0;
        repeat (n) @(posedge pclk);
    endtask
    task automatic step(logic [22:0] v, bridge_t b);
        vel(v, 1000);
        chk("bridge", bridge_state_r, b);
        chk("ampl", pwm_amplitude_r, (b == BR_VOLT_PWM) ? 8'h5A : 8'h00);
    endtask
    task automatic per(output int n);
        n = 0;
        while (n == 0 || period_tick_r !== 1'h1) @(negedge pclk) n++;
    endtask
    task print_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #450_000;
        n_mismatch++;
        print_verdict;
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        foreach (rows[i])
        begin
            apb(1'h1, rows[i].a, 32'hFFFF_FFFF);
            apb(1'h0, rows[i].a, 32'h0);
            chk("reg", rd, rows[i].q);
            chk("err", 32'(er), 32'(rows[i].e));
        end
        for (int i = 0; i < 4; i++)
        begin
            apb(1'h1, OFS_CTRL, (i << 22) | (i << 2));
            repeat (3) per(c);
            per(t);
            chk("span", c + t, span[i]);
            c = blank_r;
            repeat (59) @(negedge pclk) c += blank_r;
            chk("blank", c, blank[i]);
            @(posedge pclk);
        end
        apb(1'h1, OFS_COOL_THRS, 32'h64);
        apb(1'h1, OFS_HIGH_THRS, 32'hC8);
        apb(1'h1, OFS_CTRL, 32'h0004_5A1C);
        step(23'h32, BR_VOLT_PWM);
        step(23'h96, BR_CURR_CHOP);
        step(23'h32, BR_VOLT_PWM);
        apb(1'h1, OFS_COOL_THRS, 32'h12C);
        apb(1'h1, OFS_HIGH_THRS, 32'h78);
        step(23'h6E, BR_VOLT_PWM);
        step(23'h82, BR_CURR_CHOP);
        vel(23'h32, 1000);
        apb(1'h1, OFS_CTRL, 32'h0004_5A0C);
        repeat (4) @(posedge pclk);
        chk("vmode", voltage_mode_r, 1'h0);
        apb(1'h1, OFS_CTRL, 32'h0000_5A0C);
        repeat (4) @(posedge pclk);
        chk("bridge", bridge_state_r, BR_OFF);
        break_a <= 1'h1;
        repeat (4) @(posedge pclk);
        chk("ola", open_load_coil_a, 1'h1);
        chk("olb", open_load_coil_b, 1'h0);
        break_a <= 1'h0;
        apb(1'h1, OFS_ZERO_WAIT, 32'h8);
        apb(1'h1, OFS_CURRENT, 32'h1F00);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'h1, OFS_CTRL, 32'h0004_5A1C | (k << 16));
            standstill <= 1'h0;
            vel(23'h96, 1000);
            standstill <= 1'h1;
            vel(23'h0, 1000);
            chk("early", bridge_state_r, BR_VOLT_PWM);
            repeat (3000) @(posedge pclk);
            chk("still", bridge_state_r, opt[k]);
        end
        apb(1'h1, OFS_CTRL, 32'h0004_5A1D);
        repeat (26240) @(posedge pclk);
        apb(1'h0, OFS_STATUS, 32'h0);
        chk("frz", rd[7:0], 8'h5A);
        standstill <= 1'h0;
        vel(23'h0, 3000);
        vel(23'h96, 1000);
        apb(1'h0, OFS_STATUS, 32'h0);
        c = rd[7:0];
        chk("rise", 32'(c > 32'h5A), 32'h1);
        repeat (1000) @(posedge pclk);
        apb(1'h0, OFS_STATUS, 32'h0);
        chk("keep", rd[7:0], c);
        presetn <= 1'h0;
        @(posedge pclk);
        chk("rst", bridge_state_r, BR_OFF);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, OFS_CTRL, 32'h0);
        chk("ctrl", rd, CTRL_RST);
        apb(1'h0, OFS_CURRENT, 32'h0);
        chk("cur", rd, CURRENT_RST);
        print_verdict;
    end
endmodule // tb
